// *** verilog/ccqr_regs.vh ***
`ifndef CCQR_REGS_VH
`define CCQR_REGS_VH
// ----------------------------------------------------------------------------
// Configuration bit positions
// ----------------------------------------------------------------------------
`define CCQR_CFG_CHAIN_BIT   6
`define CCQR_CFG_SWRST_BIT   7
// ----------------------------------------------------------------------------
// RAM writes on node identifier load
// ----------------------------------------------------------------------------
`define CCQR_WAKE_ADDR0      11'h000
`define CCQR_WAKE_ADDR1      11'h001
`define CCQR_WAKE_PATTERN    8'hD1
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CCQR_CLK_PERIOD_NS   25
`define CCQR_IRQ_GAP_NS      200
`define CCQR_IRQ_GAP_CYC     ((`CCQR_IRQ_GAP_NS + `CCQR_CLK_PERIOD_NS - 1) / `CCQR_CLK_PERIOD_NS)
`define CCQR_RST_FILT_CYC    5
`endif

// *** verilog/ccqr_reset_filter.v ***
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Glitch filter for the external reset pin
// ----------------------------------------------------------------------------
module ccqr_reset_filter #(
  parameter integer FILT_CYC = 5
) (
  input  wire mclk_in,       // Device clock.
  input  wire resetn_in,     // Power-on reset, active low.
  input  wire pin_n_in,      // Raw reset pin, active low.
  output reg  hard_rst_out   // Filtered hardware reset, active high.
);

  reg       sync1_q;
  reg       sync2_q;
  reg [3:0] cnt_q;

  // Two stage synchroniser; only the second stage feeds logic.
  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= pin_n_in;
      sync2_q <= sync1_q;
    end
  end

  // A low shorter than the filter length is a glitch and is dropped.
  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_q        <= 4'h0;
      hard_rst_out <= 1'b0;
    end else if (sync2_q) begin
      cnt_q        <= 4'h0;
      hard_rst_out <= 1'b0;
    end else if (cnt_q < FILT_CYC[3:0] - 4'h1) begin
      cnt_q <= cnt_q + 4'h1;
    end else begin
      hard_rst_out <= 1'b1;
    end
  end

endmodule // ccqr_reset_filter

// *** verilog/ccqr_core.v ***
`timescale 1ns/100ps
`include "ccqr_regs.vh"
module ccqr_core #(
  parameter integer IRQ_GAP_CYC = `CCQR_IRQ_GAP_CYC,
  parameter integer FILT_CYC    = `CCQR_RST_FILT_CYC
) (
  input  wire       mclk_in,          // Device clock, 40 MHz.
  input  wire       resetn_in,        // Power-on reset, active low.
  input  wire       hard_reset_in_n,  // Raw reset pin, filtered inside, active low.
  input  wire       cfg_wr_in,        // Configuration write strobe.
  input  wire [7:0] cfg_data_in,      // Configuration write data.
  input  wire       setup_wr_in,      // Setup register write strobe.
  input  wire [7:0] setup_data_in,    // Setup register write data.
  input  wire       nid_wr_in,        // Node identifier write strobe.
  input  wire [7:0] nid_data_in,      // Node identifier data.
  input  wire       tx_en_cmd_in,     // Enable transmit from page.
  input  wire       rx_page_enable_cmd_in, // Enable receive to page.
  input  wire [2:0] page_in,          // Page for either enable.
  input  wire       tx_dis_cmd_in,    // Disable transmitter.
  input  wire       rx_dis_cmd_in,    // Disable receiver.
  input  wire       tx_irq_clr_in,    // Clear transmit interrupt.
  input  wire       rx_irq_clr_in,    // Clear receive interrupt.
  input  wire       tx_mask_in,       // Transmit available mask.
  input  wire       rx_mask_in,       // Receiver inhibited mask.
  input  wire       token_in,         // Token arrived, pulse.
  input  wire       tx_done_in,       // Transmission ended, pulse.
  input  wire       tx_acked_in,      // With tx_done_in: acked.
  input  wire       rx_start_in,      // Reception began, pulse.
  input  wire       rx_done_in,       // Reception ended, pulse.
  input  wire       enhanced_timing_flag_in, // Enhanced timing.
  output reg  [7:0] cfg_out,          // Configuration register.
  output reg  [7:0] setup_register_out, // Setup register.
  output reg  [7:0] node_identifier_out, // Node identifier.
  output reg        core_awake_out,   // Core woken by nonzero id.
  output reg        transmitter_available_out, // Level status.
  output reg        transmit_acknowledged_out, // Shown ack status.
  output reg        receiver_inhibited_out,    // Level status.
  output reg        tx_done_edge_flag_out,     // Transmit edge flag.
  output reg        rx_done_edge_flag_out,     // Receive edge flag.
  output reg        irq_out,          // Interrupt, active high.
  output reg        tx_start_out,     // Start transmit, pulse.
  output reg  [2:0] tx_page_out,      // Page being transmitted.
  output reg  [2:0] rx_page_out,      // Page being received into.
  output reg        tx_enable_out,    // Transmitter enabled.
  output reg        ram_we_out,       // RAM write strobe.
  output reg [10:0] ram_addr_out,     // RAM write address.
  output reg  [7:0] ram_data_out,     // RAM write data.
  output reg        soft_rst_out      // Core held in reset.
);
  // --------------------------------------------------------------------------
  // Reset sources
  // --------------------------------------------------------------------------
  wire hard_rst;
  wire chain = cfg_out[`CCQR_CFG_CHAIN_BIT];
  wire srst  = cfg_out[`CCQR_CFG_SWRST_BIT];
  wire any_rst = hard_rst | srst;

  ccqr_reset_filter #(
    .FILT_CYC (FILT_CYC)
  ) u_filt (
    .mclk_in      (mclk_in),
    .resetn_in    (resetn_in),
    .pin_n_in     (hard_reset_in_n),
    .hard_rst_out (hard_rst)
  );
  // --------------------------------------------------------------------------
  // Preserved registers
  // --------------------------------------------------------------------------
  // Only power-on and the filtered pin reset clear these, so soft reset keeps them.
  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cfg_out            <= 8'h00;
      setup_register_out <= 8'h00;
    end else if (hard_rst) begin
      cfg_out            <= 8'h00;
      setup_register_out <= 8'h00;
    end else begin
      if (cfg_wr_in)
        cfg_out <= cfg_data_in;
      if (setup_wr_in)
        setup_register_out <= setup_data_in;
    end
  end
  // --------------------------------------------------------------------------
  // Node identifier and wake-up RAM writes
  // --------------------------------------------------------------------------
  localparam [2:0] WK_IDLE = 3'h1;
  localparam [2:0] WK_W0   = 3'h2;
  localparam [2:0] WK_W1   = 3'h4;
  reg [2:0] wk_q;
  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wk_q                <= WK_IDLE;
      node_identifier_out <= 8'h00;
      core_awake_out      <= 1'b0;
      ram_we_out          <= 1'b0;
      ram_addr_out        <= 11'h000;
      ram_data_out        <= 8'h00;
    end else if (any_rst) begin
      wk_q                <= WK_IDLE;
      node_identifier_out <= 8'h00;
      core_awake_out      <= 1'b0;
      ram_we_out          <= 1'b0;
    end else begin
      ram_we_out <= 1'b0;
      case (wk_q)
        WK_IDLE: begin
          if (nid_wr_in) begin
            node_identifier_out <= nid_data_in;
            if (nid_data_in != 8'h00)
              wk_q <= WK_W0;
          end
        end
        WK_W0: begin
          ram_we_out   <= 1'b1;
          ram_addr_out <= `CCQR_WAKE_ADDR0;
          ram_data_out <= `CCQR_WAKE_PATTERN;
          wk_q         <= WK_W1;
        end
        WK_W1: begin
          ram_we_out     <= 1'b1;
          ram_addr_out   <= `CCQR_WAKE_ADDR1;
          ram_data_out   <= node_identifier_out;
          core_awake_out <= 1'b1;
          wk_q           <= WK_IDLE;
        end
        default: wk_q <= WK_IDLE;
      endcase
    end
  end
  // --------------------------------------------------------------------------
  // Transmit command queue
  // --------------------------------------------------------------------------
  // Entry 0 is the oldest command; it is active once started.
  reg       txq_v0_q;
  reg       txq_v1_q;
  reg [2:0] txq_p1_q;
  reg       tx_active_q;
  wire tx_en_ok = tx_en_cmd_in & (chain | ~txq_v0_q);

  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      txq_v0_q <= 1'b0;
      txq_v1_q <= 1'b0;
      txq_p1_q <= 3'h0;
      tx_active_q <= 1'b0;
      tx_page_out <= 3'h0;
      tx_start_out <= 1'b0;
      transmitter_available_out <= 1'b1;
      tx_enable_out <= 1'b0;
    end else if (any_rst) begin
      txq_v0_q <= 1'b0;
      txq_v1_q <= 1'b0;
      tx_active_q <= 1'b0;
      tx_start_out <= 1'b0;
      transmitter_available_out <= 1'b1;
      tx_enable_out <= 1'b0;
    end else begin
      tx_start_out <= 1'b0;
      tx_enable_out <= core_awake_out;
      if (tx_done_in && tx_active_q) begin
        // Completion frees the head; the queued entry waits for a token.
        transmitter_available_out <= ~txq_v1_q;
        tx_active_q <= 1'b0;
        txq_v0_q <= txq_v1_q;
        txq_v1_q <= 1'b0;
        tx_page_out <= txq_v1_q ? txq_p1_q : tx_page_out;
        if (tx_en_ok && txq_v1_q) begin
          txq_v1_q <= 1'b1;
          txq_p1_q <= page_in;
        end else if (tx_en_ok) begin
          txq_v0_q <= 1'b1;
          tx_page_out <= page_in;
        end
      end else if (tx_dis_cmd_in && txq_v0_q) begin
        // Cancels the oldest only; the shift keeps the younger one.
        txq_v0_q <= txq_v1_q;
        txq_v1_q <= 1'b0;
        tx_active_q <= 1'b0;
        tx_page_out <= txq_v1_q ? txq_p1_q : tx_page_out;
        transmitter_available_out <= ~txq_v1_q;
      end else if (tx_en_ok) begin
        transmitter_available_out <= 1'b0;
        if (!txq_v0_q) begin
          txq_v0_q <= 1'b1;
          tx_page_out <= page_in;
        end else begin
          txq_v1_q <= 1'b1;
          txq_p1_q <= page_in;
        end
      end else if (token_in && txq_v0_q && !tx_active_q) begin
        // The queued entry starts as if freshly commanded.
        tx_active_q <= 1'b1;
        tx_start_out <= 1'b1;
        transmitter_available_out <= 1'b0;
      end
    end
  end
  // --------------------------------------------------------------------------
  // Receive command queue
  // --------------------------------------------------------------------------
  reg       rxq_v0_q;
  reg       rxq_v1_q;
  reg [2:0] rxq_p1_q;
  reg       rx_busy_q;
  wire rx_en_ok = rx_page_enable_cmd_in & (chain | ~rxq_v0_q);

  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rxq_v0_q <= 1'b0;
      rxq_v1_q <= 1'b0;
      rxq_p1_q <= 3'h0;
      rx_busy_q <= 1'b0;
      rx_page_out <= 3'h0;
      receiver_inhibited_out <= 1'b1;
    end else if (any_rst) begin
      rxq_v0_q <= 1'b0;
      rxq_v1_q <= 1'b0;
      rx_busy_q <= 1'b0;
      receiver_inhibited_out <= 1'b1;
    end else begin
      if (rx_start_in && rxq_v0_q)
        rx_busy_q <= 1'b1;
      if (rx_done_in && rx_busy_q) begin
        // Next packet goes straight to the queued page.
        rx_busy_q <= 1'b0;
        rxq_v0_q <= rxq_v1_q | (rx_en_ok & rxq_v1_q);
        rxq_v1_q <= rx_en_ok & rxq_v1_q;
        rx_page_out <= rxq_v1_q ? rxq_p1_q : rx_page_out;
        receiver_inhibited_out <= ~rxq_v1_q & ~rx_en_ok;
        if (rx_en_ok && rxq_v1_q)
          rxq_p1_q <= page_in;
        else if (rx_en_ok) begin
          rxq_v0_q <= 1'b1;
          rx_page_out <= page_in;
        end
      end else if (rx_dis_cmd_in && rxq_v0_q && !rx_busy_q) begin
        // A reception in progress is never cut short.
        rxq_v0_q <= rxq_v1_q;
        rxq_v1_q <= 1'b0;
        rx_page_out <= rxq_v1_q ? rxq_p1_q : rx_page_out;
        receiver_inhibited_out <= ~rxq_v1_q;
      end else if (rx_en_ok) begin
        receiver_inhibited_out <= 1'b0;
        if (!rxq_v0_q) begin
          rxq_v0_q <= 1'b1;
          rx_page_out <= page_in;
        end else begin
          rxq_v1_q <= 1'b1;
          rxq_p1_q <= page_in;
        end
      end
    end
  end
  // --------------------------------------------------------------------------
  // Completion status double buffers
  // --------------------------------------------------------------------------
  // Slot 0 is shown; slot 1 holds a result waiting for acknowledge.
  reg tx_c1_q;
  reg tx_a1_q;
  reg rx_c1_q;
  wire tx_ev = tx_done_in & tx_active_q;
  wire rx_ev = rx_done_in & rx_busy_q;
  wire tx_pop = tx_irq_clr_in & tx_done_edge_flag_out;
  wire rx_pop = rx_irq_clr_in & rx_done_edge_flag_out;

  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_done_edge_flag_out <= 1'b0;
      transmit_acknowledged_out <= 1'b0;
      tx_c1_q <= 1'b0;
      tx_a1_q <= 1'b0;
      rx_done_edge_flag_out <= 1'b0;
      rx_c1_q <= 1'b0;
    end else if (any_rst) begin
      tx_done_edge_flag_out <= 1'b0;
      transmit_acknowledged_out <= 1'b0;
      tx_c1_q <= 1'b0;
      rx_done_edge_flag_out <= 1'b0;
      rx_c1_q <= 1'b0;
    end else begin
      // Transmit side: a new event in the clear cycle is not lost.
      if (tx_en_ok && !txq_v0_q && !tx_done_edge_flag_out)
        transmit_acknowledged_out <= 1'b0;
      if (tx_pop) begin
        tx_done_edge_flag_out <= tx_c1_q | tx_ev;
        transmit_acknowledged_out <= tx_c1_q ? tx_a1_q : tx_acked_in;
        tx_c1_q <= tx_c1_q & tx_ev;
        tx_a1_q <= tx_acked_in;
      end else if (tx_ev && !tx_done_edge_flag_out) begin
        tx_done_edge_flag_out <= 1'b1;
        transmit_acknowledged_out <= tx_acked_in;
      end else if (tx_ev) begin
        tx_c1_q <= 1'b1;
        tx_a1_q <= tx_acked_in;
      end
      // Receive side mirrors the transmit side.
      if (rx_pop) begin
        rx_done_edge_flag_out <= rx_c1_q | rx_ev;
        rx_c1_q <= rx_c1_q & rx_ev;
      end else if (rx_ev && !rx_done_edge_flag_out)
        rx_done_edge_flag_out <= 1'b1;
      else if (rx_ev)
        rx_c1_q <= 1'b1;
    end
  end
  // --------------------------------------------------------------------------
  // Interrupt with minimum inactive gap
  // --------------------------------------------------------------------------
  // The gap is held after any drop other than by reset so that back to back flags edge twice.
  reg [7:0] gap_q;
  wire irq_req = (tx_done_edge_flag_out & (tx_mask_in | ~chain))
               | (rx_done_edge_flag_out & (rx_mask_in | ~chain));
  wire gap_on = enhanced_timing_flag_in & (gap_q != 8'h00);

  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_out <= 1'b0;
      gap_q   <= 8'h00;
    end else if (any_rst) begin
      irq_out <= 1'b0;
      gap_q   <= 8'h00;
    end else if (irq_out && (!irq_req || tx_pop || rx_pop)) begin
      irq_out <= 1'b0;
      gap_q   <= IRQ_GAP_CYC[7:0];
    end else if (gap_q != 8'h00) begin
      gap_q <= gap_q - 8'h01;
      if (!gap_on)
        irq_out <= irq_req;
    end else begin
      irq_out <= irq_req;
    end
  end
  // --------------------------------------------------------------------------
  // Reset indication, soft or filtered pin
  // --------------------------------------------------------------------------
  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in)
      soft_rst_out <= 1'b0;
    else
      soft_rst_out <= any_rst;
  end
endmodule // ccqr_core

// *** test/ccqr_checker.sv ***
`timescale 1ns/100ps
`include "ccqr_regs.vh"
// ------
// Port checker
// ------
module ccqr_checker #(
  parameter integer IRQ_GAP_CYC = 8
) (
  input wire        mclk_in,                   // Clock.
  input wire        resetn_in,                 // Reset, active low.
  input wire        cfg_wr_in,                 // Config write.
  input wire  [7:0] cfg_data_in,               // Config data.
  input wire        nid_wr_in,                 // Node id write.
  input wire  [7:0] nid_data_in,               // Node id data.
  input wire        tx_en_cmd_in,              // Transmit enable.
  input wire  [2:0] page_in,                   // Command page.
  input wire        tx_irq_clr_in,             // Transmit clear.
  input wire        rx_irq_clr_in,             // Receive clear.
  input wire        tx_mask_in,                // Transmit mask.
  input wire        rx_mask_in,                // Receive mask.
  input wire        token_in,                  // Token pulse.
  input wire        enhanced_timing_flag_in,   // Gap enable.
  input wire  [7:0] cfg_out,                   // Config.
  input wire        transmitter_available_out, // Available.
  input wire        transmit_acknowledged_out, // Acknowledged.
  input wire        tx_done_edge_flag_out,     // Transmit flag.
  input wire        rx_done_edge_flag_out,     // Receive flag.
  input wire        irq_out,                   // Interrupt.
  input wire        tx_start_out,              // Send start.
  input wire  [2:0] tx_page_out,               // Send page.
  input wire        tx_enable_out,             // Transmitter on.
  input wire        ram_we_out,                // RAM write.
  input wire [10:0] ram_addr_out,              // RAM address.
  input wire  [7:0] ram_data_out,              // RAM data.
  input wire        soft_rst_out               // Soft reset.
);
  reg [7:0] gap_q;  // Low cycles of the interrupt since it last stood.

  // Saturate so that a long idle time never wraps into a false short gap.
  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in)
      gap_q <= 8'hFF;
    else if (irq_out)
      gap_q <= 8'h00;
    else if (gap_q != 8'hFF)
      gap_q <= gap_q + 8'h01;
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);

  // ------
  // Properties
  // ------
  chk_irq_cause: assert property ($rose(irq_out) |->
    $past(tx_done_edge_flag_out && (tx_mask_in || !cfg_out[6]) ||
          rx_done_edge_flag_out && (rx_mask_in || !cfg_out[6])))
    else $error("irq without flag");
  chk_irq_gap: assert property ($rose(irq_out) &&
    enhanced_timing_flag_in |-> gap_q >= IRQ_GAP_CYC)
    else $error("interrupt gap too short");
  chk_tx_flag_hold: assert property ($fell(tx_done_edge_flag_out) |->
    $past(tx_irq_clr_in) || $past(tx_irq_clr_in, 2) ||
    soft_rst_out || $past(soft_rst_out))
    else $error("tx flag fell early");
  chk_rx_flag_hold: assert property ($fell(rx_done_edge_flag_out) |->
    $past(rx_irq_clr_in) || $past(rx_irq_clr_in, 2) ||
    soft_rst_out || $past(soft_rst_out))
    else $error("rx flag fell early");
  chk_start_token: assert property ($rose(tx_start_out) |->
    $past(token_in) || $past(token_in, 2))
    else $error("start without token");
  chk_first_enable: assert property (tx_en_cmd_in &&
    transmitter_available_out && !cfg_out[6] && !soft_rst_out |=>
    !transmitter_available_out && !transmit_acknowledged_out &&
    tx_page_out == $past(page_in))
    else $error("first enable wrong");
  chk_wake_writes: assert property (nid_wr_in &&
    nid_data_in != 8'h00 && !soft_rst_out |-> ##2
    (ram_we_out && ram_addr_out == `CCQR_WAKE_ADDR0 &&
     ram_data_out == `CCQR_WAKE_PATTERN) ##1
    (ram_we_out && ram_addr_out == `CCQR_WAKE_ADDR1 &&
     ram_data_out == $past(nid_data_in, 3)))
    else $error("wake writes wrong");
  chk_soft_quiet: assert property (soft_rst_out |=> !tx_enable_out &&
    !irq_out && !tx_done_edge_flag_out && !rx_done_edge_flag_out)
    else $error("reset left state");
  chk_cfg_kept: assert property (cfg_wr_in |=>
    cfg_out == $past(cfg_data_in))
    else $error("config write not kept");

  cover property ($rose(tx_start_out));
  cover property ($rose(irq_out) && rx_done_edge_flag_out);
  cover property (ram_we_out && ram_addr_out == `CCQR_WAKE_ADDR1);
endmodule // ccqr_checker

// *** test/ccqr_link_model.sv ***
`timescale 1ns/100ps
// ------
// Link side stand-in
// ------
module ccqr_link_model #(
  parameter integer TX_LAT = 2  // Send length in cycles, 1 to 8.
) (
  input  wire mclk_in,      // Clock.
  input  wire resetn_in,    // Reset, active low.
  input  wire tx_start_out, // Send begins.
  input  wire ack_mode_in,  // Far node acknowledges.
  input  wire rx_go_in,     // Play one frame.
  output reg  tx_done_in,   // Send ended.
  output reg  tx_acked_in,  // Acknowledge with the end.
  output reg  rx_start_in,  // Frame begins.
  output reg  rx_done_in    // Frame stored.
);
  reg [7:0] tx_sr_q;  // Send in flight.
  reg [3:0] rx_sr_q;  // Frame in flight.

  // Delay lines; acknowledge stands only beside the end pulse.
  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_sr_q <= 8'h00;
      rx_sr_q <= 4'h0;
      tx_done_in <= 1'b0;
      tx_acked_in <= 1'b0;
      rx_start_in <= 1'b0;
      rx_done_in <= 1'b0;
    end else begin
      tx_sr_q <= {tx_sr_q[6:0], tx_start_out};
      rx_sr_q <= {rx_sr_q[2:0], rx_go_in};
      tx_done_in <= tx_sr_q[TX_LAT-1];
      tx_acked_in <= tx_sr_q[TX_LAT-1] & ack_mode_in;
      rx_start_in <= rx_go_in;
      rx_done_in <= rx_sr_q[3];
    end
  end
endmodule // ccqr_link_model

// *** test/tb_top.sv ***
`timescale 1ns/100ps
// ------
// Self-checking bench
// ------
module tb_top;
  reg        mclk_in = 1'b0;
  reg        resetn_in, hard_reset_in_n, tx_mask_in, rx_mask_in;
  reg        enhanced_timing_flag_in, ack_mode;
  reg  [7:0] cmd_v, wd;
  reg  [2:0] wr_v, page_in;
  integer    n_errors, checks, n;
  wire       tx_en_cmd_in = cmd_v[0], rx_page_enable_cmd_in = cmd_v[1];
  wire       tx_dis_cmd_in = cmd_v[2], rx_dis_cmd_in = cmd_v[3];
  wire       tx_irq_clr_in = cmd_v[4], rx_irq_clr_in = cmd_v[5];
  wire       token_in = cmd_v[6], rx_go = cmd_v[7];
  wire       cfg_wr_in = wr_v[0], setup_wr_in = wr_v[1], nid_wr_in = wr_v[2];
  wire [7:0] cfg_data_in = wd, setup_data_in = wd, nid_data_in = wd;
  wire       tx_done_in, tx_acked_in, rx_start_in, rx_done_in, core_awake_out;
  wire       transmitter_available_out, transmit_acknowledged_out, irq_out;
  wire       receiver_inhibited_out, tx_done_edge_flag_out, tx_start_out;
  wire       rx_done_edge_flag_out, tx_enable_out, ram_we_out, soft_rst_out;
  wire [7:0] cfg_out, setup_register_out, node_identifier_out, ram_data_out;
  wire [2:0] tx_page_out, rx_page_out;
  wire [10:0] ram_addr_out;
  wire [7:0] stat = {3'h0, transmitter_available_out, tx_done_edge_flag_out,
                     rx_done_edge_flag_out, irq_out, transmit_acknowledged_out};

  always #12.5 mclk_in = ~mclk_in;

  ccqr_core dut (.*);
  ccqr_link_model link (.mclk_in, .resetn_in, .tx_start_out,
    .ack_mode_in(ack_mode), .rx_go_in(rx_go), .tx_done_in, .tx_acked_in,
    .rx_start_in, .rx_done_in);

  // ------
  // Helpers
  // ------
  task end_sim;
    begin
      if (n_errors == 0 && checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task tick(input integer k);
    begin
      repeat (k) @(posedge mclk_in);
      #1;
    end
  endtask
  // One command pulse: 0 tx en, 1 rx en, 2 tx dis, 3 rx dis, 4 tx clr,
  // 5 rx clr, 6 token, 7 frame from the link model.
  task cmd(input integer c, input [2:0] pg);
    begin
      @(posedge mclk_in);
      page_in <= pg;
      cmd_v <= 8'h01 << c;
      @(posedge mclk_in);
      cmd_v <= 8'h00;
      #1;
    end
  endtask
  task wr(input integer w, input [7:0] d);
    begin
      @(posedge mclk_in);
      wd <= d;
      wr_v <= 3'h1 << w;
      @(posedge mclk_in);
      wr_v <= 3'h0;
      #1;
    end
  endtask
  function sig(input integer w);
    case (w)
      0: sig = tx_done_edge_flag_out;
      1: sig = rx_done_edge_flag_out;
      2: sig = ram_we_out;
      3: sig = tx_start_out;
      default: sig = irq_out;
    endcase
  endfunction
  // Bounded wait; running out ends the run as a failure.
  task wait_for(input integer w, output integer k);
    begin
      k = 0;
      while (sig(w) !== 1'b1 && k < 60) begin
        tick(1);
        k = k + 1;
      end
      if (k == 60) begin
        n_errors = n_errors + 1;
        $display("unexpected at %0t: wait ran out", $time);
        end_sim;
      end
    end
  endtask
  task pin(input integer len);
    begin
      @(posedge mclk_in);
      hard_reset_in_n <= 1'b0;
      repeat (len) @(posedge mclk_in);
      hard_reset_in_n <= 1'b1;
      tick(10);
    end
  endtask

  // ------
  // Scenarios
  // ------
  task s_reset_and_wake;
    begin
      chk(cfg_out, 8'h00);
      chk(stat, 8'h10);
      chk({6'h00, tx_enable_out, soft_rst_out}, 8'h00);
      chk({7'h00, receiver_inhibited_out}, 8'h01);
      wr(1, 8'h5A);
      wr(2, 8'h12);
      wait_for(2, n);
      chk({ram_addr_out[7:0]}, 8'h00);
      chk(ram_data_out, 8'hD1);
      tick(1);
      chk({ram_we_out, ram_addr_out[6:0]}, 8'h81);
      chk(ram_data_out, 8'h12);
      tick(1);
      chk({7'h00, core_awake_out}, 8'h01);
      chk(node_identifier_out, 8'h12);
    end
  endtask
  task s_tx_plain;
    begin
      cmd(0, 3'h3);
      tick(1);
      chk(stat, 8'h00);
      cmd(0, 3'h5);
      ack_mode = 1'b1;
      cmd(6, 3'h0);
      wait_for(3, n);
      chk({5'h00, tx_page_out}, 8'h03);
      wait_for(0, n);
      tick(2);
      chk(stat, 8'h1B);
      cmd(4, 3'h0);
      tick(1);
      chk(stat & 8'h1E, 8'h10);
    end
  endtask
  task s_tx_chain;
    begin
      wr(0, 8'h40);
      cmd(0, 3'h1);
      cmd(0, 3'h2);
      ack_mode = 1'b0;
      cmd(6, 3'h0);
      wait_for(0, n);
      tick(2);
      chk(stat & 8'h0F, 8'h0A);
      ack_mode = 1'b1;
      cmd(6, 3'h0);
      wait_for(3, n);
      chk({5'h00, tx_page_out}, 8'h02);
      tick(6);
      chk(stat & 8'h0F, 8'h0A);
      cmd(4, 3'h0);
      tick(1);
      chk({7'h00, irq_out}, 8'h00);
      wait_for(4, n);
      chk({7'h00, n >= 6}, 8'h01);
      chk(stat & 8'h0F, 8'h0B);
      cmd(4, 3'h0);
    end
  endtask
  task s_tx_cancel;
    begin
      tx_mask_in <= 1'b0;
      cmd(0, 3'h4);
      cmd(0, 3'h6);
      cmd(2, 3'h0);
      cmd(6, 3'h0);
      tick(3);
      cmd(6, 3'h0);
      wait_for(0, n);
      tick(3);
      chk({5'h00, tx_page_out}, 8'h06);
      chk(stat & 8'h0F, 8'h09);
      cmd(4, 3'h0);
      tick(12);
      chk(stat & 8'h0E, 8'h00);
      tx_mask_in <= 1'b1;
    end
  endtask
  task s_rx;
    begin
      cmd(1, 3'h1);
      cmd(1, 3'h2);
      cmd(7, 3'h0);
      wait_for(1, n);
      cmd(7, 3'h0);
      tick(8);
      chk(stat & 8'h06, 8'h06);
      cmd(5, 3'h0);
      tick(1);
      chk({7'h00, irq_out}, 8'h00);
      wait_for(4, n);
      chk(stat & 8'h06, 8'h06);
      cmd(5, 3'h0);
      cmd(1, 3'h5);
      cmd(7, 3'h0);
      tick(1);
      cmd(3, 3'h0);
      wait_for(1, n);
      chk({5'h00, rx_page_out}, 8'h05);
      cmd(5, 3'h0);
    end
  endtask
  task s_resets;
    begin
      cmd(0, 3'h7);
      wr(0, 8'hC0);
      tick(1);
      chk(cfg_out, 8'hC0);
      chk({6'h00, tx_enable_out, soft_rst_out}, 8'h01);
      chk({7'h00, receiver_inhibited_out}, 8'h01);
      chk(node_identifier_out, 8'h00);
      wr(0, 8'h40);
      tick(1);
      chk(setup_register_out, 8'h5A);
      cmd(6, 3'h0);
      tick(8);
      chk(stat & 8'h1E, 8'h10);
      pin(3);
      chk(cfg_out, 8'h40);
      pin(8);
      chk(cfg_out, 8'h00);
      chk(stat & 8'h1E, 8'h10);
    end
  endtask

  // Main sequence.
  initial begin
    n_errors = 0;
    checks = 0;
    cmd_v = 8'h00;
    wr_v = 3'h0;
    wd = 8'h00;
    page_in = 3'h0;
    resetn_in = 1'b0;
    hard_reset_in_n = 1'b1;
    tx_mask_in = 1'b1;
    rx_mask_in = 1'b1;
    enhanced_timing_flag_in = 1'b1;
    ack_mode = 1'b0;
    repeat (4) @(posedge mclk_in);
    resetn_in <= 1'b1;
    tick(2);
    s_reset_and_wake;
    s_tx_plain;
    s_tx_chain;
    s_tx_cancel;
    s_rx;
    s_resets;
    end_sim;
  end
endmodule // tb_top

bind ccqr_core ccqr_checker #(.IRQ_GAP_CYC(IRQ_GAP_CYC)) u_chk (.*);
